// File: hw/rcs_decoder.sv
// Purpose: Decodes context switch, store and semaphore-tail fields from a command stream
// Assumes: Dwords arrive with valid/ready; context engine and memory side are on clock
// Notes: Command stream never stalls on write completion
//
// Summary of operation
// - Compare-register bit selects register operand
// - Bit 17 picks video or blitter sync
// - Length field is total dwords minus two
// - Continue only if semaphore exceeds data
// - Dword 2 address: memory or register
// - Decode type 0, opcodes 16h/18h/20h/21h
// - New context: save old, load new
// - Same context address: no operation
// - Context address bits 31:12, then stored
// - Force restore reloads matching context
// - Restore inhibit skips the load
// - Force/inhibit not kept in context register
// - Immediate store is snooped write
// - Non-secure global store: byte enables off
// - Store address bits 31:2, dword aligned
// - Quadword: dword 3 low, dword 4 high
// - Issue write, continue without waiting
// - Indexed store offsets status page base
// - Bit 22 indexes probe list instead
`timescale 1ns/1ps
module rcs_decoder
   import rcs_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [31:0] cmdData,
   input wire logic cmdValid,
   output logic cmdReady,
   input wire logic secureBatch,
   input wire logic [19:0] statusPageBase,
   input wire logic [19:0] probeListBase,
   input wire logic [31:0] videoSyncReg,
   input wire logic [31:0] blitterSyncReg,
   input wire logic [31:0] semMemValue,
   output logic semMemReq,
   output logic [29:0] semMemAddr,
   input wire logic semMemValid,
   output logic [29:0] semRegAddr,
   output logic semWait,
   output logic semPass,
   output rcs_pkg::rcs_ctx_t ctxReq,
   output logic ctxReqValid,
   input wire logic ctxDone,
   output logic [19:0] currentContextReg,
   output rcs_pkg::rcs_wr_t wr,
   output logic wrValid,
   input wire logic wrReady
);
   import rcs_pkg::*;

   typedef enum logic [2:0] {
      S_HEAD = 3'b000,
      S_BODY = 3'b001,
      S_EXEC = 3'b011,
      S_WAIT = 3'b010,
      S_SKIP = 3'b110
   } rcs_state_t;

   typedef enum logic [1:0] {
      K_SEMA = 2'b00,
      K_CTX = 2'b01,
      K_SIMM = 2'b10,
      K_SIDX = 2'b11
   } rcs_kind_t;

   // Header classification, used at head and in assertions
   function automatic logic isOurs(input logic [31:0] h);
      logic [5:0] op;
      op = h[OPC_HI:OPC_LO];
      isOurs = (h[TYPE_HI:TYPE_LO] == TYPE_MI) &&
               (op == OPC_SEMA || op == OPC_CTX || op == OPC_SIMM || op == OPC_SIDX);
   endfunction : isOurs

   rcs_state_t state_q;
   rcs_kind_t kind_q;
   logic [31:0] hdr_q;
   logic [31:0] dw_q [0:4];
   logic [7:0] idx_q;
   logic [7:0] total_q;
   logic storeBusy;
   logic storeStart;
   logic [29:0] storeAddr;
   logic take;
   logic [19:0] newCtx;
   logic sameCtx;
   logic force_b;
   logic inhibit_b;
   logic lastWord;

   // ****************************************
   // Stream intake
   // ****************************************
   assign cmdReady = (state_q == S_HEAD) || (state_q == S_BODY) || (state_q == S_SKIP);
   assign take = cmdValid && cmdReady;
   // Header dword counts as index 0; total is length plus bias
   assign lastWord = (idx_q + 8'h01 == total_q);

   // ****************************************
   // Command state machine
   // ****************************************
   // Unknown headers are passed over one dword at a time, they are not ours
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q <= S_HEAD;
         kind_q <= K_SEMA;
         hdr_q <= 32'h0000_0000;
         idx_q <= 8'h00;
         total_q <= 8'h00;
      end else begin
         unique case (state_q)
            S_HEAD: begin
               if (take && isOurs(cmdData)) begin
                  hdr_q <= cmdData;
                  idx_q <= 8'h01;
                  total_q <= cmdData[LEN_HI:LEN_LO] + LEN_BIAS;
                  unique case (cmdData[OPC_HI:OPC_LO])
                     OPC_CTX: kind_q <= K_CTX;
                     OPC_SIMM: kind_q <= K_SIMM;
                     OPC_SIDX: kind_q <= K_SIDX;
                     default: kind_q <= K_SEMA;
                  endcase
                  state_q <= S_BODY;
               end
            end
            S_BODY: begin
               if (take) begin
                  idx_q <= idx_q + 8'h01;
                  if (lastWord) begin
                     state_q <= S_EXEC;
                  end else if (idx_q == 8'h04) begin
                     state_q <= S_SKIP;
                  end
               end
            end
            S_SKIP: begin
               // Extra dwords past the formats are drained
               if (take) begin
                  idx_q <= idx_q + 8'h01;
                  if (lastWord) begin
                     state_q <= S_EXEC;
                  end
               end
            end
            S_EXEC: begin
               state_q <= S_WAIT;
            end
            S_WAIT: begin
               if (kind_q == K_CTX) begin
                  if (ctxDone || !ctxReqValid) begin
                     state_q <= S_HEAD;
                  end
               end else if (kind_q == K_SEMA) begin
                  if (semPass) begin
                     state_q <= S_HEAD;
                  end
               end else if (!storeBusy) begin
                  // Only the issue slot is awaited, never completion
                  state_q <= S_HEAD;
               end
            end
            default: state_q <= S_HEAD;
         endcase
      end
   end

   // ****************************************
   // Body dword capture
   // ****************************************
   generate
      for (genvar i = 1; i < 5; i++) begin : g_dw
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               dw_q[i] <= 32'h0000_0000;
            end else if (take && state_q == S_BODY && idx_q == 8'(i)) begin
               dw_q[i] <= cmdData;
            end
         end
      end
   endgenerate
   assign dw_q[0] = hdr_q;

   // ****************************************
   // Context switch decisions
   // ****************************************
   assign newCtx = dw_q[1][31:CTX_ADDR_LO];
   assign force_b = dw_q[1][CTX_FORCE_BIT];
   assign inhibit_b = dw_q[1][CTX_INHIBIT_BIT];
   assign sameCtx = (newCtx == currentContextReg);

   // Save only on change; load on change or force, never under inhibit
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctxReq <= '0;
         ctxReqValid <= 1'b0;
      end else if (state_q == S_EXEC && kind_q == K_CTX) begin
         ctxReq.doSave <= !sameCtx;
         ctxReq.doLoad <= (!sameCtx || force_b) && !inhibit_b;
         ctxReq.saveAddr <= currentContextReg;
         ctxReq.loadAddr <= newCtx;
         ctxReqValid <= !sameCtx || force_b;
      end else if (ctxDone) begin
         ctxReqValid <= 1'b0;
      end
   end

   // Register keeps only the address, not the one-shot controls
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         currentContextReg <= CTX_RESET;
      end else if (state_q == S_WAIT && kind_q == K_CTX && ctxReqValid && ctxDone) begin
         currentContextReg <= ctxReq.loadAddr;
      end
   end

   // ****************************************
   // Semaphore tail
   // ****************************************
   // Operand from sync register or memory read
   logic useReg;
   logic [31:0] regOperand;
   logic memGot_q;
   logic [31:0] memVal_q;
   assign useReg = hdr_q[SEM_CMPREG_BIT];
   assign regOperand = hdr_q[SEM_REGSEL_BIT] ? blitterSyncReg : videoSyncReg;
   assign semMemAddr = dw_q[2][31:ADDR_LO];
   assign semRegAddr = dw_q[2][31:ADDR_LO];
   assign semMemReq = (state_q == S_WAIT) && (kind_q == K_SEMA) && !useReg &&
                      hdr_q[SEM_COMPARE_BIT];

   // Memory operand is re-read while the wait lasts, else a failed compare hangs
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         memGot_q <= 1'b0;
         memVal_q <= 32'h0000_0000;
      end else if (state_q != S_WAIT) begin
         memGot_q <= 1'b0;
      end else if (semMemReq && semMemValid) begin
         memGot_q <= 1'b1;
         memVal_q <= semMemValue;
      end
   end

   // Continue only on strictly greater; no compare passes at once
   always_comb begin
      semPass = 1'b0;
      if (state_q == S_WAIT && kind_q == K_SEMA) begin
         if (!hdr_q[SEM_COMPARE_BIT]) begin
            semPass = 1'b1;
         end else if (useReg) begin
            semPass = regOperand > dw_q[1];
         end else begin
            semPass = memGot_q && (memVal_q > dw_q[1]);
         end
      end
   end
   assign semWait = (state_q == S_WAIT) && (kind_q == K_SEMA) && !semPass;

   // ****************************************
   // Store commands
   // ****************************************
   // Reserved bits of dword 0 and 1 are never looked at
   always_comb begin
      if (kind_q == K_SIMM) begin
         storeAddr = dw_q[2][31:ADDR_LO];
      end else if (hdr_q[SIDX_PROBE_BIT]) begin
         storeAddr = {probeListBase, 10'h000} + {20'h0_0000, dw_q[1][SIDX_OFF_HI:ADDR_LO]};
      end else begin
         storeAddr = {statusPageBase, 10'h000} + {20'h0_0000, dw_q[1][SIDX_OFF_HI:ADDR_LO]};
      end
   end

   assign storeStart = (state_q == S_EXEC) && (kind_q == K_SIMM || kind_q == K_SIDX);

   rcs_store_path u_store (
      .clock(clock),
      .rst(rst),
      .start(storeStart),
      .baseAddr(storeAddr),
      .dataLo(kind_q == K_SIMM ? dw_q[3] : dw_q[2]),
      .dataHi(kind_q == K_SIMM ? dw_q[4] : dw_q[3]),
      .qword(kind_q == K_SIMM ? (hdr_q[LEN_HI:LEN_LO] == 8'h03) : (hdr_q[LEN_HI:LEN_LO] == 8'h02)),
      .zeroBe(kind_q == K_SIMM && hdr_q[ST_GLOBAL_BIT] && !secureBatch),
      .busy(storeBusy),
      .wr(wr),
      .wrValid(wrValid),
      .wrReady(wrReady)
   );

   // ****************************************
   // Checks
   // ****************************************
   property p_hdr_decode;
      @(posedge clock) disable iff (rst)
      (state_q == S_HEAD && take && isOurs(cmdData)) |=> (state_q == S_BODY);
   endproperty
   a_hdr_decode: assert property (p_hdr_decode) else $error("header not decoded");

   property p_len;
      @(posedge clock) disable iff (rst)
      (state_q == S_HEAD && take && isOurs(cmdData))
         |=> (total_q == $past(cmdData[7:0]) + 8'h02);
   endproperty
   a_len: assert property (p_len) else $error("length bias wrong");

   property p_same_noop;
      @(posedge clock) disable iff (rst)
      (state_q == S_EXEC && kind_q == K_CTX && sameCtx && !force_b) |=> !ctxReqValid;
   endproperty
   a_same_noop: assert property (p_same_noop) else $error("same context not skipped");

   property p_save_new;
      @(posedge clock) disable iff (rst)
      (state_q == S_EXEC && kind_q == K_CTX && !sameCtx)
         |=> (ctxReq.doSave && ctxReqValid && ctxReq.saveAddr == $past(currentContextReg));
   endproperty
   a_save_new: assert property (p_save_new) else $error("old context not saved");

   property p_force;
      @(posedge clock) disable iff (rst)
      (state_q == S_EXEC && kind_q == K_CTX && force_b && !inhibit_b) |=> ctxReq.doLoad;
   endproperty
   a_force: assert property (p_force) else $error("force restore ignored");

   property p_inhibit;
      @(posedge clock) disable iff (rst)
      (state_q == S_EXEC && kind_q == K_CTX && inhibit_b) |=> !ctxReq.doLoad;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("inhibit did not block load");

   property p_current_context_reg;
      @(posedge clock) disable iff (rst)
      (state_q == S_WAIT && kind_q == K_CTX && ctxReqValid && ctxDone)
         |=> (currentContextReg == $past(ctxReq.loadAddr));
   endproperty
   a_current_context_reg: assert property (p_current_context_reg) else $error("context register not updated");

   property p_sem_gt;
      @(posedge clock) disable iff (rst)
      (semPass && hdr_q[SEM_COMPARE_BIT]) |-> ((useReg ? (hdr_q[SEM_REGSEL_BIT] ?
         blitterSyncReg : videoSyncReg) : memVal_q) > dw_q[1]);
   endproperty
   a_sem_gt: assert property (p_sem_gt) else $error("semaphore passed without greater");

   property p_store_issue;
      @(posedge clock) disable iff (rst)
      storeStart |=> (wrValid && wr.snoop && wr.dwAddr == $past(storeAddr));
   endproperty
   a_store_issue: assert property (p_store_issue) else $error("store not issued snooped");

   property p_be_off;
      @(posedge clock) disable iff (rst)
      (storeStart && kind_q == K_SIMM && hdr_q[22] && !secureBatch) |=> (wr.byteEn == 4'h0);
   endproperty
   a_be_off: assert property (p_be_off) else $error("byte enables not off");
endmodule : rcs_decoder

// File: hw/rcs_pkg.sv
// Purpose: Shared constants and carrier types for the ring context/store decoder
// Assumes: 32-bit command dwords, one dword offered per cycle
// Notes: Field positions and opcodes are the command formats' own
package rcs_pkg;
   // ****************************************
   // Command header fields
   // ****************************************
   localparam int TYPE_HI = 31;
   localparam int TYPE_LO = 29;
   localparam int OPC_HI = 28;
   localparam int OPC_LO = 23;
   localparam int LEN_HI = 7;
   localparam int LEN_LO = 0;
   localparam logic [2:0] TYPE_MI = 3'h0;
   localparam logic [5:0] OPC_SEMA = 6'h16;
   localparam logic [5:0] OPC_CTX = 6'h18;
   localparam logic [5:0] OPC_SIMM = 6'h20;
   localparam logic [5:0] OPC_SIDX = 6'h21;
   localparam logic [7:0] LEN_BIAS = 8'h02;
   // ****************************************
   // Per-command bit positions
   // ****************************************
   localparam int SEM_CMPREG_BIT = 18;
   localparam int SEM_REGSEL_BIT = 17;
   localparam int SEM_COMPARE_BIT = 20;
   localparam int SEM_UPDATE_BIT = 21;
   localparam int CTX_FORCE_BIT = 1;
   localparam int CTX_INHIBIT_BIT = 0;
   localparam int CTX_ADDR_LO = 12;
   localparam int ST_GLOBAL_BIT = 22;
   localparam int SIDX_PROBE_BIT = 22;
   localparam int ADDR_LO = 2;
   localparam int SIDX_OFF_HI = 11;
   localparam logic [19:0] CTX_RESET = 20'h0000_0;
   localparam logic [3:0] BE_ALL = 4'hf;
   localparam logic [3:0] BE_NONE = 4'h0;

   // Memory write carrier
   typedef struct packed {
      logic [29:0] dwAddr;
      logic [31:0] data;
      logic [3:0] byteEn;
      logic snoop;
   } rcs_wr_t;

   // Context engine request carrier
   typedef struct packed {
      logic doSave;
      logic doLoad;
      logic [19:0] saveAddr;
      logic [19:0] loadAddr;
   } rcs_ctx_t;
endpackage : rcs_pkg

// File: hw/rcs_store_path.sv
// Purpose: Issues one or two dword memory writes for a store command
// Assumes: Memory side accepts a write whenever wrReady is high
// Notes: Fire-and-forget; no completion is tracked
`timescale 1ns/1ps
module rcs_store_path
   import rcs_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic start,
   input wire logic [29:0] baseAddr,
   input wire logic [31:0] dataLo,
   input wire logic [31:0] dataHi,
   input wire logic qword,
   input wire logic zeroBe,
   output logic busy,
   output rcs_pkg::rcs_wr_t wr,
   output logic wrValid,
   input wire logic wrReady
);
   logic pending_q;
   logic second_q;
   logic [31:0] hi_q;

   // ****************************************
   // Write sequencing
   // ****************************************
   // Lower dword first, upper dword at the next address
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pending_q <= 1'b0;
         second_q <= 1'b0;
         hi_q <= 32'h0000_0000;
         wr <= '0;
      end else if (start) begin
         pending_q <= 1'b1;
         second_q <= qword;
         hi_q <= dataHi;
         wr.dwAddr <= baseAddr;
         wr.data <= dataLo;
         wr.byteEn <= zeroBe ? BE_NONE : BE_ALL;
         wr.snoop <= 1'b1;
      end else if (pending_q && wrReady) begin
         if (second_q) begin
            second_q <= 1'b0;
            wr.dwAddr <= wr.dwAddr + 30'h0000_0001;
            wr.data <= hi_q;
         end else begin
            pending_q <= 1'b0;
         end
      end
   end

   assign wrValid = pending_q;
   assign busy = pending_q;

   // Second write carries the held upper dword at address plus one
   property p_qw_upper;
      @(posedge clock) disable iff (rst)
      (wrValid && wrReady && second_q) |=> (wr.data == $past(hi_q) && wrValid);
   endproperty
   a_qw_upper: assert property (p_qw_upper) else $error("upper dword not sent");
endmodule : rcs_store_path

// File: tb/rcs_mem_model.sv
// Purpose: Memory side and context engine facing the decoder
// Assumes: One write beat per dword; slow mode stretches every acceptance
// Notes: No write completion goes back; semaphore reads answer after two cycles
`timescale 1ns/1ps
module rcs_mem_model
   import rcs_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic slow,
   input rcs_pkg::rcs_wr_t wr,
   input wire logic wrValid,
   output logic wrReady,
   input wire logic ctxReqValid,
   output logic ctxDone,
   input wire logic semMemReq,
   input wire logic [31:0] memSemValue,
   output logic semMemValid,
   output logic [31:0] semMemValue,
   output rcs_pkg::rcs_wr_t accWr,
   output logic accPulse
);
   logic [1:0] wrCnt_q;
   logic [1:0] ctxCnt_q;
   logic [1:0] semCnt_q;
   // Slow mode holds off acceptance for three cycles
   assign wrReady = wrValid && (!slow || wrCnt_q == 2'h3);
   // Idle read data is inverted so a stale sample cannot pass a compare
   assign semMemValid = semMemReq && semCnt_q == 2'h2;
   assign semMemValue = semMemValid ? memSemValue : ~memSemValue;
   // Write acceptance, reported to the bench as a one-cycle pulse
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wrCnt_q <= 2'h0;
         accPulse <= 1'b0;
         accWr <= '0;
      end else begin
         wrCnt_q <= (wrValid && !wrReady) ? wrCnt_q + 2'h1 : 2'h0;
         accPulse <= wrValid && wrReady; // Accept only, nothing returned
         if (wrValid && wrReady) begin
            accWr <= wr;
         end
      end
   end
   // Context engine and semaphore read latency
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctxCnt_q <= 2'h0;
         ctxDone <= 1'b0;
         semCnt_q <= 2'h0;
      end else begin
         ctxCnt_q <= (ctxReqValid && !ctxDone) ? ctxCnt_q + 2'h1 : 2'h0;
         ctxDone <= ctxReqValid && !ctxDone && ctxCnt_q == 2'h2;
         semCnt_q <= !semMemReq ? 2'h0 : (semCnt_q == 2'h2 ? semCnt_q : semCnt_q + 2'h1);
      end
   end
endmodule : rcs_mem_model

// File: tb/ring_context_store_commands_test.sv
// Purpose: Self-checking bench for the ring context/store decoder
// Assumes: Inputs change on the falling edge; the model answers memory and context
// Notes: Expectations are built from the command fields sent
`timescale 1ns/1ps
module ring_context_store_commands_test;
   import rcs_pkg::*;
   logic clock, rst, cmdValid, cmdReady, secureBatch, semMemReq, semMemValid;
   logic semWait, semPass, ctxReqValid, ctxDone, wrValid, wrReady, slow, accPulse, ctxSeen;
   logic semSeen;
   logic [31:0] cmdData, videoSyncReg, blitterSyncReg, semMemValue, memSemValue;
   logic [19:0] statusPageBase, probeListBase, currentContextReg, cur;
   logic [29:0] semMemAddr, semRegAddr;
   rcs_ctx_t ctxReq, seenReq;
   rcs_wr_t wr, accWr;
   int fails, tests_run, cycles;
   // ****************************************
   // Design and partner
   // ****************************************
   rcs_decoder u_rcs_decoder (.clock(clock), .rst(rst), .cmdData(cmdData),
      .cmdValid(cmdValid), .cmdReady(cmdReady), .secureBatch(secureBatch),
      .statusPageBase(statusPageBase), .probeListBase(probeListBase),
      .videoSyncReg(videoSyncReg), .blitterSyncReg(blitterSyncReg),
      .semMemValue(semMemValue), .semMemReq(semMemReq), .semMemAddr(semMemAddr),
      .semMemValid(semMemValid), .semRegAddr(semRegAddr), .semWait(semWait),
      .semPass(semPass), .ctxReq(ctxReq), .ctxReqValid(ctxReqValid), .ctxDone(ctxDone),
      .currentContextReg(currentContextReg), .wr(wr), .wrValid(wrValid), .wrReady(wrReady));
   rcs_mem_model u_rcs_mem_model (.clock(clock), .rst(rst), .slow(slow), .wr(wr),
      .wrValid(wrValid), .wrReady(wrReady), .ctxReqValid(ctxReqValid), .ctxDone(ctxDone),
      .semMemReq(semMemReq), .memSemValue(memSemValue), .semMemValid(semMemValid),
      .semMemValue(semMemValue), .accWr(accWr), .accPulse(accPulse));
   // ****************************************
   // Clock, watchdog and request monitor
   // ****************************************
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // Cut a hang short well beyond the expected run length
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         finish_test();
      end
   end
   // Remember any context request, since it clears while the bench is busy
   always @(posedge clock) begin
      if (ctxReqValid === 1'b1) begin
         ctxSeen <= 1'b1;
         seenReq <= ctxReq;
      end
      // Pass stands one cycle only, so it is latched here
      if (semPass === 1'b1) begin
         semSeen <= 1'b1;
      end
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // Offer dwords back to back, holding each until taken
   task automatic sendCmd(input logic [31:0] d[$]);
      int n;
      foreach (d[i]) begin
         cmdData = d[i];
         cmdValid = 1'b1;
         n = 0;
         while (cmdReady !== 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
         end
         @(negedge clock);
      end
      cmdValid = 1'b0;
      @(negedge clock);
   endtask : sendCmd
   task automatic expectWr(input logic [29:0] a, input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      while (accPulse !== 1'b1 && n < 60) begin
         @(negedge clock);
         n++;
      end
      check("wrAddr", accWr.dwAddr, a);
      check("wrData", accWr.data, d);
      check("wrByteEn", accWr.byteEn, be);
      check("wrSnoop", accWr.snoop, 1'b1);
      @(negedge clock);
   endtask : expectWr
   // Reserved header bits are set on purpose; they must change nothing
   task automatic storeImm(input logic [29:0] a, input logic [31:0] lo, input logic [31:0] hi,
         input logic qw, input logic glb);
      logic [31:0] h;
      logic [3:0] be;
      h = {TYPE_MI, OPC_SIMM, glb, 14'h1555, qw ? 8'h03 : 8'h02};
      be = (glb && !secureBatch) ? BE_NONE : BE_ALL;
      if (qw) begin
         sendCmd('{h, 32'h0000_0000, {a, 2'b00}, lo, hi});
      end else begin
         sendCmd('{h, 32'h0000_0000, {a, 2'b00}, lo});
      end
      expectWr(a, lo, be);
      if (qw) begin
         expectWr(a + 30'h0000_0001, hi, be);
      end
   endtask : storeImm
   task automatic idxStore(input logic [9:0] off, input logic [31:0] d, input logic probe);
      sendCmd('{{TYPE_MI, OPC_SIDX, probe, 14'h0000, 8'h01}, {20'h0000_0, off, 2'b00}, d});
      expectWr({probe ? probeListBase : statusPageBase, 10'h000} + {20'h0000_0, off}, d, BE_ALL);
   endtask : idxStore
   // Every switch is followed by exactly one no-operation dword
   task automatic ctxTest(input logic [19:0] a, input logic frc, input logic inh);
      logic exp;
      ctxSeen = 1'b0;
      exp = (a != cur) || frc;
      sendCmd('{{TYPE_MI, OPC_CTX, 15'h0000, 8'h00}, {a, 3'h0, 1'b1, 6'h00, frc, inh},
         32'h0000_0000});
      check("ctxSeen", ctxSeen, exp);
      if (exp) begin
         check("doLoad", seenReq.doLoad, !inh);
         check("loadAddr", seenReq.loadAddr, a);
         if (a != cur) begin
            check("doSave", seenReq.doSave, 1'b1);
            check("saveAddr", seenReq.saveAddr, cur);
         end
      end
      check("ctxReg", currentContextReg, a);
      cur = a;
   endtask : ctxTest
   // Operand equal to the data first (must block), then one above (must pass)
   task automatic semTest(input logic mem, input logic sel, input logic [31:0] d,
         input logic [29:0] a);
      int n;
      memSemValue = d;
      videoSyncReg = (mem || sel) ? d + 32'h0000_0005 : d;
      blitterSyncReg = (mem || !sel) ? d + 32'h0000_0005 : d;
      semSeen = 1'b0;
      sendCmd('{{TYPE_MI, OPC_SEMA, 3'b001, 1'b0, !mem, sel, 9'h000, 8'h01}, d, {a, 2'b00}});
      repeat (6) @(negedge clock);
      check("semWait", semWait, 1'b1);
      check("semPass", semSeen, 1'b0);
      if (mem) begin
         check("semMemReq", semMemReq, 1'b1);
         check("semMemAddr", semMemAddr, a);
         memSemValue = d + 32'h0000_0001;
      end else begin
         check("semRegAddr", semRegAddr, a);
         if (sel) begin
            blitterSyncReg = d + 32'h0000_0001;
         end else begin
            videoSyncReg = d + 32'h0000_0001;
         end
      end
      n = 0;
      while (semSeen !== 1'b1 && n < 40) begin
         @(negedge clock);
         n++;
      end
      check("semPassed", semSeen, 1'b1);
      @(negedge clock);
   endtask : semTest
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      fails = 0;
      tests_run = 0;
      cycles = 0;
      rst = 1'b1;
      cmdData = 32'h0000_0000;
      cmdValid = 1'b0;
      secureBatch = 1'b1;
      statusPageBase = 20'h1234_5;
      probeListBase = 20'h0abc_d;
      videoSyncReg = 32'h0000_0000;
      blitterSyncReg = 32'h0000_0000;
      memSemValue = 32'h0000_0000;
      slow = 1'b0;
      ctxSeen = 1'b0;
      semSeen = 1'b0;
      cur = CTX_RESET;
      repeat (12) @(negedge clock);
      rst = 1'b0;
      @(negedge clock);
      check("ctxRegReset", currentContextReg, CTX_RESET);
      storeImm(30'h0123_4567, 32'hdead_beef, 32'h0000_0000, 1'b0, 1'b0);
      storeImm(30'h0000_1002, 32'h1111_2222, 32'h3333_4444, 1'b1, 1'b0);
      slow = 1'b1;
      storeImm(30'h3fff_fffe, 32'h5555_aaaa, 32'haaaa_5555, 1'b1, 1'b1);
      slow = 1'b0;
      secureBatch = 1'b0;
      storeImm(30'h0000_0040, 32'h0bad_f00d, 32'h0000_0000, 1'b0, 1'b1);
      storeImm(30'h0000_0044, 32'h600d_f00d, 32'h0000_0000, 1'b0, 1'b0);
      secureBatch = 1'b1;
      idxStore(10'h010, 32'hcafe_0001, 1'b0);
      idxStore(10'h3ff, 32'hcafe_0002, 1'b1);
      ctxTest(20'h0010_0, 1'b0, 1'b0);
      ctxTest(20'h0010_0, 1'b0, 1'b0);
      ctxTest(20'h0010_0, 1'b1, 1'b0);
      ctxTest(20'h0010_0, 1'b0, 1'b0);
      ctxTest(20'h0020_0, 1'b0, 1'b1);
      semTest(1'b0, 1'b0, 32'h0000_0100, 30'h0000_2a00);
      semTest(1'b0, 1'b1, 32'h7fff_ffff, 30'h0000_2b00);
      semTest(1'b1, 1'b0, 32'h0000_0033, 30'h0123_0000);
      finish_test();
   end
endmodule : ring_context_store_commands_test
